// ==== seet_defines.svh ====
`ifndef SEET_DEFINES_SVH
`define SEET_DEFINES_SVH

// array and page geometry
`define SEET_MEM_BYTES      8192
`define SEET_PAGE_BYTES     32
`define SEET_WORD_BITS      8

// self-timed write cycle, longest time as printed, and the core clock rate
`define SEET_T_WR_MS        5
`define SEET_CORE_CLK_KHZ   125000

`endif

// ==== seet_pkg.sv ====
`default_nettype none

package seet_pkg;

  // protocol position inside one transfer
  typedef enum logic [2:0]
  {
    SEET_IDLE,
    SEET_DEV,
    SEET_AHI,
    SEET_ALO,
    SEET_WDATA,
    SEET_RDATA
  } seet_state_t;

  // pin levels that travel together through the synchroniser
  typedef struct packed
  {
    logic       scl;
    logic       sda;
    logic       wp;
    logic [2:0] strap;
  } seet_pins_t;

endpackage : seet_pkg

`default_nettype wire

// ==== seet_target.sv ====
`include "seet_defines.svh"
`default_nettype none

module seet_target #(
  parameter int         MEM_BYTES = `SEET_MEM_BYTES,
  parameter int         PAGE_BYTES = `SEET_PAGE_BYTES,
  // type code value is arbitrary
  parameter logic [3:0] TYPE_CODE = 4'h5,
  parameter int         WR_CYCLES = `SEET_T_WR_MS * `SEET_CORE_CLK_KHZ
)(
  input  wire logic core_clk,
  input  wire logic arst_n,
  input  wire logic scl_clk,
  input  wire logic sda_in,
  output logic      sda_out,
  output logic      sda_oe,
  input  wire logic write_protect,
  input  wire logic chip_select_strap_0,
  input  wire logic chip_select_strap_1,
  input  wire logic chip_select_strap_2,
  output logic      standby,
  output logic      write_busy
);
  import seet_pkg::*;

  localparam int AW = $clog2(MEM_BYTES);
  localparam int PW = $clog2(PAGE_BYTES);
  localparam int TW = $clog2(WR_CYCLES + 1);
  localparam int WB = `SEET_WORD_BITS;

  // link domain: each rising bus clock edge samples the data line and flips a toggle
  logic bit_tgl_reg;
  logic bit_tgl_next;
  logic bit_val_reg;
  logic bit_val_next;

  always_comb
  begin
    bit_tgl_next = ~bit_tgl_reg;
    bit_val_next = sda_in;
  end

  always_ff @(posedge scl_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      bit_tgl_reg <= 1'b0;
      bit_val_reg <= 1'b1;
    end
    else
    begin
      bit_tgl_reg <= bit_tgl_next;
      bit_val_reg <= bit_val_next;
    end
  end

  // core domain synchronisers for pins and the bit toggle
  seet_pins_t pins_raw;
  seet_pins_t pins_meta_reg;
  seet_pins_t pins_sync_reg;
  seet_pins_t pins_prev_reg;
  logic       tgl_meta_reg;
  logic       tgl_sync_reg;
  logic       tgl_prev_reg;

  always_comb
  begin
    pins_raw.scl   = scl_clk;
    pins_raw.sda   = sda_in;
    pins_raw.wp    = write_protect;
    pins_raw.strap = {chip_select_strap_2, chip_select_strap_1, chip_select_strap_0};
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      pins_meta_reg <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0, strap: 3'h0};
      pins_sync_reg <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0, strap: 3'h0};
      pins_prev_reg <= '{scl: 1'b1, sda: 1'b1, wp: 1'b0, strap: 3'h0};
      tgl_meta_reg  <= 1'b0;
      tgl_sync_reg  <= 1'b0;
      tgl_prev_reg  <= 1'b0;
    end
    else
    begin
      pins_meta_reg <= pins_raw;
      pins_sync_reg <= pins_meta_reg;
      pins_prev_reg <= pins_sync_reg;
      tgl_meta_reg  <= bit_tgl_reg;
      tgl_sync_reg  <= tgl_meta_reg;
      tgl_prev_reg  <= tgl_sync_reg;
    end
  end

  logic start_ev;
  logic stop_ev;
  logic bit_ev;
  logic fall_ev;

  // both levels pass the same two stages, so start and stop keep their order
  assign start_ev = pins_sync_reg.scl & pins_prev_reg.scl & pins_prev_reg.sda & ~pins_sync_reg.sda;
  assign stop_ev  = pins_sync_reg.scl & pins_prev_reg.scl & ~pins_prev_reg.sda & pins_sync_reg.sda;
  assign bit_ev   = tgl_sync_reg ^ tgl_prev_reg;
  assign fall_ev  = pins_prev_reg.scl & ~pins_sync_reg.scl;

  // protocol state
  seet_state_t       state_reg;
  seet_state_t       state_next;
  logic [3:0]        cnt_reg;
  logic [3:0]        cnt_next;
  logic [WB-1:0]     sr_reg;
  logic [WB-1:0]     sr_next;
  logic [WB-1:0]     tx_reg;
  logic [WB-1:0]     tx_next;
  logic [WB-1:0]     ahi_reg;
  logic [WB-1:0]     ahi_next;
  logic [AW-1:0]     addr_reg;
  logic [AW-1:0]     addr_next;
  logic              ack_reg;
  logic              ack_next;
  logic              oe_reg;
  logic              oe_next;
  logic              wr_pend_reg;
  logic              wr_pend_next;
  logic [TW-1:0]     timer_reg;
  logic [TW-1:0]     timer_next;
  logic              commit_reg;
  logic              commit_next;
  logic [PW-1:0]     cidx_reg;
  logic [PW-1:0]     cidx_next;
  logic [WB-1:0]     pbuf_reg [PAGE_BYTES];
  logic [WB-1:0]     pbuf_next [PAGE_BYTES];
  logic [PAGE_BYTES-1:0] pvalid_reg;
  logic [PAGE_BYTES-1:0] pvalid_next;

  logic [WB-1:0]     mem [MEM_BYTES];
  logic [AW-1:0]     rd_addr;
  logic [WB-1:0]     rd_data;
  logic [WB-1:0]     rx;
  logic [15:0]       word_addr;
  logic              busy;
  logic              match;

  assign busy      = (timer_reg != '0) | commit_reg;
  assign rx        = {sr_reg[WB-2:0], bit_val_reg};
  assign word_addr = {ahi_reg, rx};
  // next byte of a sequential read is fetched ahead, so the first bit is ready at the fall
  assign rd_addr   = (state_reg == SEET_RDATA) ? AW'(addr_reg + 1'b1) : addr_reg;
  assign rd_data   = mem[rd_addr];
  assign match     = (rx[7:4] == TYPE_CODE) & (rx[3:1] == pins_sync_reg.strap) & ~busy;

  always_comb
  begin
    state_next   = state_reg;
    cnt_next     = cnt_reg;
    sr_next      = sr_reg;
    tx_next      = tx_reg;
    ahi_next     = ahi_reg;
    addr_next    = addr_reg;
    ack_next     = ack_reg;
    oe_next      = oe_reg;
    wr_pend_next = wr_pend_reg;
    timer_next   = (timer_reg != '0) ? TW'(timer_reg - 1'b1) : timer_reg;
    commit_next  = commit_reg;
    cidx_next    = cidx_reg;
    pbuf_next    = pbuf_reg;
    pvalid_next  = pvalid_reg;

    // programming walks the page buffer one byte per cycle while the timer runs
    if (commit_reg)
    begin
      cidx_next = PW'(cidx_reg + 1'b1);
      if (cidx_reg == PW'(PAGE_BYTES - 1))
      begin
        commit_next = 1'b0;
        pvalid_next = '0;
      end
    end

    if (start_ev)
    begin
      state_next = SEET_DEV;
      cnt_next   = 4'h0;
      oe_next    = 1'b0;
      ack_next   = 1'b0;
    end
    else if (stop_ev)
    begin
      state_next   = SEET_IDLE;
      oe_next      = 1'b0;
      wr_pend_next = 1'b0;
      if (state_reg == SEET_WDATA && wr_pend_reg && !pins_sync_reg.wp && !busy)
      begin
        timer_next  = TW'(WR_CYCLES);
        commit_next = 1'b1;
        cidx_next   = '0;
      end
      else if (!commit_reg)
      begin
        pvalid_next = '0;
      end
    end
    else if (bit_ev && state_reg != SEET_IDLE)
    begin
      if (cnt_reg != 4'h8)
      begin
        sr_next  = rx;
        cnt_next = 4'(cnt_reg + 1'b1);
        if (cnt_reg == 4'h7)
        begin
          ack_next = 1'b0;
          unique case (state_reg)
            SEET_DEV:
            begin
              ack_next = match;
            end
            SEET_AHI:
            begin
              ack_next = 1'b1;
              ahi_next = rx;
            end
            SEET_ALO:
            begin
              ack_next  = 1'b1;
              addr_next = word_addr[AW-1:0];
            end
            SEET_WDATA:
            begin
              ack_next                         = 1'b1;
              pbuf_next[addr_reg[PW-1:0]]      = rx;
              pvalid_next[addr_reg[PW-1:0]]    = 1'b1;
              wr_pend_next                     = 1'b1;
            end
            SEET_RDATA:
            begin
              ack_next = 1'b0;
            end
            SEET_IDLE:
            begin
              ack_next = 1'b0;
            end
          endcase
        end
      end
      else
      begin
        cnt_next = 4'h0;
        unique case (state_reg)
          SEET_DEV:
          begin
            if (!ack_reg)
            begin
              state_next = SEET_IDLE;
            end
            else if (sr_reg[0])
            begin
              state_next = SEET_RDATA;
              tx_next    = rd_data;
            end
            else
            begin
              state_next = SEET_AHI;
            end
          end
          SEET_AHI:
          begin
            state_next = SEET_ALO;
          end
          SEET_ALO:
          begin
            state_next   = SEET_WDATA;
            pvalid_next  = '0;
            wr_pend_next = 1'b0;
          end
          SEET_WDATA:
          begin
            addr_next = {addr_reg[AW-1:PW], PW'(addr_reg[PW-1:0] + 1'b1)};
          end
          SEET_RDATA:
          begin
            addr_next = AW'(addr_reg + 1'b1);
            if (bit_val_reg)
            begin
              state_next = SEET_IDLE;
            end
            else
            begin
              tx_next = rd_data;
            end
          end
          SEET_IDLE:
          begin
            state_next = SEET_IDLE;
          end
        endcase
      end
    end
    else if (fall_ev)
    begin
      // apart from the release at a start or stop, drive changes wait for the clock to go low
      if (state_reg == SEET_IDLE)
      begin
        oe_next = 1'b0;
      end
      else if (cnt_reg == 4'h8)
      begin
        oe_next = (state_reg != SEET_RDATA) & ack_reg;
      end
      else if (state_reg == SEET_RDATA)
      begin
        oe_next = ~tx_reg[3'(4'h7 - cnt_reg)];
      end
      else
      begin
        oe_next = 1'b0;
      end
    end
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      state_reg   <= SEET_IDLE;
      cnt_reg     <= 4'h0;
      sr_reg      <= 8'h00;
      tx_reg      <= 8'h00;
      ahi_reg     <= 8'h00;
      addr_reg    <= '0;
      ack_reg     <= 1'b0;
      oe_reg      <= 1'b0;
      wr_pend_reg <= 1'b0;
      timer_reg   <= '0;
      commit_reg  <= 1'b0;
      cidx_reg    <= '0;
      pbuf_reg    <= '{default: 8'h00};
      pvalid_reg  <= '0;
    end
    else
    begin
      state_reg   <= state_next;
      cnt_reg     <= cnt_next;
      sr_reg      <= sr_next;
      tx_reg      <= tx_next;
      ahi_reg     <= ahi_next;
      addr_reg    <= addr_next;
      ack_reg     <= ack_next;
      oe_reg      <= oe_next;
      wr_pend_reg <= wr_pend_next;
      timer_reg   <= timer_next;
      commit_reg  <= commit_next;
      cidx_reg    <= cidx_next;
      pbuf_reg    <= pbuf_next;
      pvalid_reg  <= pvalid_next;
    end
  end

  // the array has no reset, as a real nonvolatile store would not
  always_ff @(posedge core_clk)
  begin
    if (commit_reg && pvalid_reg[cidx_reg])
    begin
      mem[{addr_reg[AW-1:PW], cidx_reg}] <= pbuf_reg[cidx_reg];
    end
  end

  assign sda_out    = 1'b0;
  assign sda_oe     = oe_reg;
  assign standby    = (state_reg == SEET_IDLE) & ~busy;
  assign write_busy = busy;

endmodule // seet_target

`default_nettype wire

// ==== seet_target_sva.sv ====
`default_nettype none

module seet_target_sva #(
  parameter int WR_CYCLES = 625000
)(
  input wire logic core_clk,
  input wire logic arst_n,
  input wire logic scl_clk,
  input wire logic sda_in,
  input wire logic sda_out,
  input wire logic sda_oe,
  input wire logic write_protect,
  input wire logic standby,
  input wire logic write_busy
);
  logic [19:0] busy_cnt_reg;
  logic [19:0] busy_cnt_next;

  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!arst_n);

  // counts the cycles of one write cycle, so its length can be checked exactly
  always_comb
  begin
    busy_cnt_next = write_busy ? busy_cnt_reg + 20'h0_0001 : 20'h0_0000;
  end

  always_ff @(posedge core_clk or negedge arst_n)
  begin
    if (!arst_n)
      busy_cnt_reg <= 20'h0_0000;
    else
      busy_cnt_reg <= busy_cnt_next;
  end

  a_drive_only_low: assert property (!sda_out) else $error("data pin driven high");
  a_ack_clock_low: assert property ($rose(sda_oe) |-> !scl_clk) else $error("pull-down with clock high");
  a_ack_holds: assert property ($rose(sda_oe) |-> sda_oe[*8]) else $error("pull-down too short");
  a_busy_silent: assert property (write_busy |-> !sda_oe) else $error("answer in write cycle");
  a_busy_not_idle: assert property (write_busy |-> !standby) else $error("standby during write");
  a_idle_silent: assert property (standby |-> !sda_oe) else $error("standby but driving");
  a_write_on_stop: assert property ($rose(write_busy) |-> scl_clk && sda_in)
    else $error("write cycle without stop");
  a_protect_blocks: assert property ($rose(write_busy) |-> !$past(write_protect, 4))
    else $error("protected write programmed");
  a_write_length: assert property ($fell(write_busy) |-> busy_cnt_reg == 20'(WR_CYCLES))
    else $error("write cycle length");

  c_write: cover property ($rose(write_busy));
  c_answer: cover property ($rose(sda_oe));
  c_active: cover property ($fell(standby));
endmodule // seet_target_sva

bind seet_target seet_target_sva #(.WR_CYCLES(WR_CYCLES)) i_sva (
  .core_clk, .arst_n, .scl_clk, .sda_in, .sda_out, .sda_oe, .write_protect, .standby, .write_busy
);

`default_nettype wire

// ==== seet_bus_ctrl.sv ====
`default_nettype none

module seet_bus_ctrl (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  timeunit 1ns;
  timeprecision 1ps;
  // eight ticks of the 15 ns link base; the device answers 2-3 core clocks after a fall
  localparam time T = 120ns;

  initial
  begin
    scl     = 1'b1;
    sda_low = 1'b0;
  end

  task automatic bit_io(input logic b, output logic r);
    #(T / 4) sda_low = !b;
    #(T - T / 4) scl = 1'b1;
    r = sda;
    #T scl = 1'b0;
  endtask

  task automatic start;
    sda_low = 1'b0;
    #T scl = 1'b1;
    #T sda_low = 1'b1;
    #T scl = 1'b0;
  endtask

  // clock stays high after a stop, so the link stands still between frames
  task automatic stop;
    sda_low = 1'b1;
    #T scl = 1'b1;
    #T sda_low = 1'b0;
    #T;
  endtask

  task automatic put(input logic [7:0] d, output logic nak);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], r);
    bit_io(1'b1, nak);
  endtask

  task automatic get(input logic nak, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(nak, r);
  endtask
endmodule // seet_bus_ctrl

`default_nettype wire

// ==== serial_eeprom_two_wire_target_tb.sv ====
`default_nettype none

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin fail_count++; \
  $display("wrong value at %0t ns: got %h want %h", $time, a, b); end end

module serial_eeprom_two_wire_target_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // long enough that a poll lands inside the write cycle
  localparam int         WR = 600;
  localparam logic [3:0] TC = 4'h5; // arbitrary type code
  logic       core_clk = 1'b0;
  logic       arst_n = 1'b0;
  logic       wp = 1'b0;
  logic [2:0] strap = 3'b101;
  logic       scl;
  logic       ctl_low;
  logic       sda_oe;
  logic       sda_out;
  logic       standby;
  logic       write_busy;
  wire        sda;
  int         fail_count = 0;
  int         total_checks = 0;
  int         cyc = 0;

  assign sda = !(ctl_low | (sda_oe & !sda_out));
  always #4 core_clk = !core_clk;

  seet_bus_ctrl i_ctl (.scl(scl), .sda_low(ctl_low), .sda(sda));
  seet_target #(.TYPE_CODE(TC), .WR_CYCLES(WR)) i_dut (
    .core_clk(core_clk), .arst_n(arst_n), .scl_clk(scl), .sda_in(sda), .sda_out(sda_out),
    .sda_oe(sda_oe), .write_protect(wp), .chip_select_strap_0(strap[0]), .chip_select_strap_1(strap[1]),
    .chip_select_strap_2(strap[2]), .standby(standby), .write_busy(write_busy));

  task automatic dev(input logic rd, output logic nak);
    i_ctl.start;
    i_ctl.put({TC, strap, rd}, nak);
  endtask

  task automatic open_at(input logic [15:0] a);
    logic n0, n1, n2;
    dev(1'b0, n0);
    i_ctl.put(a[15:8], n1);
    i_ctl.put(a[7:0], n2);
    `CHK({n0, n1, n2}, 3'b000)
  endtask

  task automatic read_at(input logic [15:0] a, input logic [7:0] e);
    logic       n;
    logic [7:0] d;
    open_at(a);
    dev(1'b1, n);
    i_ctl.get(1'b1, d);
    i_ctl.stop;
    `CHK({n, d}, {1'b0, e})
    `CHK(standby, 1'b1)
  endtask

  task automatic wait_idle;
    // look between edges, so the flag read is the settled one
    for (int i = 0; i < WR + 50 && write_busy !== 1'b0; i++)
      @(negedge core_clk);
    `CHK(write_busy, 1'b0)
  endtask

  task automatic t_byte_write;
    logic n;
    open_at(16'h0000);
    i_ctl.put(8'hA5, n);
    i_ctl.stop;
    `CHK({n, write_busy, standby}, 3'b010)
    dev(1'b0, n);
    i_ctl.stop;
    `CHK(n, 1'b1)
    wait_idle;
    dev(1'b0, n);
    i_ctl.stop;
    `CHK({n, write_busy}, 2'b00)
  endtask

  task automatic t_page_wrap;
    logic [2:0] n;
    open_at(16'hFFFE);
    i_ctl.put(8'h11, n[0]);
    i_ctl.put(8'h22, n[1]);
    i_ctl.put(8'h33, n[2]);
    i_ctl.stop;
    `CHK(n, 3'b000)
    wait_idle;
    read_at(16'h1FE0, 8'h33);
    read_at(16'h1FFE, 8'h11);
  endtask

  task automatic t_reads;
    logic       n;
    logic [7:0] d0, d1;
    dev(1'b1, n);
    i_ctl.get(1'b1, d0);
    i_ctl.stop;
    `CHK({n, d0}, 9'h022)
    open_at(16'h1FFF);
    dev(1'b1, n);
    i_ctl.get(1'b0, d0);
    i_ctl.get(1'b1, d1);
    i_ctl.stop;
    `CHK({d0, d1}, 16'h22A5)
  endtask

  task automatic t_protect;
    logic n;
    @(negedge core_clk) wp = 1'b1;
    open_at(16'h0000);
    i_ctl.put(8'h5A, n);
    i_ctl.stop;
    repeat (8) @(negedge core_clk);
    `CHK({n, write_busy}, 2'b00)
    @(negedge core_clk) wp = 1'b0;
    read_at(16'h0000, 8'hA5);
  endtask

  task automatic t_mismatch;
    logic [7:0] w [4] = '{8'h6A, 8'h58, 8'h5E, 8'h52};
    logic       n;
    foreach (w[i])
    begin
      i_ctl.start;
      i_ctl.put(w[i], n);
      i_ctl.stop;
      `CHK({n, standby}, 2'b11)
    end
    @(negedge core_clk) strap = 3'b010;
    read_at(16'h0000, 8'hA5);
  endtask

  task automatic t_recover;
    logic n;
    logic r;
    // a written byte, so the device is caught pulling the line low mid-read
    open_at(16'h0000);
    dev(1'b1, n);
    repeat (3) i_ctl.bit_io(1'b1, r);
    i_ctl.start;
    repeat (9) i_ctl.bit_io(1'b1, r);
    i_ctl.start;
    i_ctl.stop;
    `CHK(standby, 1'b1)
    read_at(16'h0000, 8'hA5);
  endtask

  task automatic give_verdict;
    $display("checks %0d, mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge core_clk)
  begin
    cyc++;
    if (cyc == 40000)
    begin
      fail_count++;
      give_verdict;
    end
  end

  initial
  begin
    repeat (4) @(posedge core_clk);
    @(negedge core_clk) arst_n = 1'b1;
    repeat (4) @(negedge core_clk);
    `CHK({sda_oe, sda_out, standby, write_busy}, 4'b0010)
    t_byte_write;
    t_page_wrap;
    t_reads;
    t_protect;
    t_mismatch;
    t_recover;
    give_verdict;
  end
endmodule // serial_eeprom_two_wire_target_tb

`default_nettype wire
